// ===== core/priority_crossbar_port_io.sv
`timescale 1ns/100ps
// Operation
// - functions ranked fixed; serial port first; placement follows rank order
// - enabled function takes lowest free pin, serial pins excepted
// - serial transmit on port 0 bit 4, receive on port 0 bit 5
// - already assigned pins are passed over
// - skip mask bits act like assigned pins
// - smbus enable claims sda and scl together
// - serial enable claims transmit and receive together
// - leftover pins are ordinary port i/o
// - spi claims three pins, four with nss in four-wire mode
// - input mode bit: 1 digital, 0 analog
// - analog pin: pull-up, driver and receiver off
// - reset leaves every pin a digital input
// - output mode bit picks open-drain or push-pull, peripherals too
// - sda and scl pins always open-drain
// - pull-up on open-drain pins while disable bit is 0
// - pull-up off when driving low or analog
// - crossbar disabled: all pins are plain inputs
// - drivers disabled while crossbar is disabled
// - port read returns live pin level
// - crossbar enable is bit 6 of function select 1
// - capture pin count 0..6 outputs, 7 reserved
// - latch 1 on open-drain pin leaves it high impedance
module priority_crossbar_port_io (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire xbar_pkg::port_cfg_s i_cfg,
  input wire logic [7:0] i_function_select_0,
  input wire logic [7:0] i_function_select_1,
  input wire logic [1:0] i_slave_select_mode_bits,
  input wire xbar_pkg::periph_out_s i_periph,
  input wire logic [23:0] i_pin,
  output logic [23:0] o_pin_out,
  output logic [23:0] o_pin_oe,
  output logic [23:0] o_pin_pullup,
  output logic [23:0] o_port_read,
  output logic [xbar_pkg::NUM_SLOTS-1:0] o_periph_in,
  output logic o_serial_receive_pin
);
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  xbar_pkg::port_cfg_s cfg;
  logic [7:0] fsel0;
  logic [7:0] fsel1;
  logic [1:0] nss_mode;
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;

  // settings are registered so outputs follow two cycles later
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg.input_mode <= xbar_pkg::RST_INPUT_MODE;
      cfg.output_mode <= xbar_pkg::RST_OUTPUT_MODE;
      cfg.skip <= xbar_pkg::RST_SKIP;
      cfg.latch <= xbar_pkg::RST_LATCH;
      fsel0 <= xbar_pkg::RST_FSEL;
      fsel1 <= xbar_pkg::RST_FSEL;
      nss_mode <= 2'h0;
    end else begin
      cfg <= i_cfg;
      fsel0 <= i_function_select_0;
      fsel1 <= i_function_select_1;
      nss_mode <= i_slave_select_mode_bits;
    end
  end

  // pins come from outside, two flops before anything reads them
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_meta <= 24'h000000;
      pin_sync <= 24'h000000;
    end else begin
      pin_meta <= i_pin;
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // slot enables
  // ---------------------------------------------------------------
  logic xbar_en;
  logic uart_en;
  logic [xbar_pkg::NUM_SLOTS-1:0] slot_en;
  logic [2:0] cap_cnt;
  logic four_wire;

  assign xbar_en = fsel1[xbar_pkg::FS1_XBAR_EN];
  assign uart_en = fsel0[xbar_pkg::FS0_UART];
  assign cap_cnt = fsel1[xbar_pkg::FS1_CAP_LO +: 3];
  assign four_wire = nss_mode[1]; // nss routed only in 4-wire mode

  // fixed rank list; lower index is higher priority
  always_comb begin
    slot_en = '0;
    slot_en[2:0] = {3{fsel0[xbar_pkg::FS0_SPI]}};
    slot_en[xbar_pkg::SLOT_NSS] = fsel0[xbar_pkg::FS0_SPI] & four_wire;
    slot_en[xbar_pkg::SLOT_SDA] = fsel0[xbar_pkg::FS0_SMB];
    slot_en[xbar_pkg::SLOT_SCL] = fsel0[xbar_pkg::FS0_SMB];
    slot_en[6] = fsel0[xbar_pkg::FS0_CP0];
    slot_en[7] = fsel0[xbar_pkg::FS0_CP0A];
    slot_en[8] = fsel0[xbar_pkg::FS0_SYSCK];
    slot_en[9] = fsel0[xbar_pkg::FS0_CP1];
    slot_en[10] = fsel0[xbar_pkg::FS0_CP1A];
    for (int k = 0; k < 6; k++) begin
      // reserved count routes nothing
      slot_en[xbar_pkg::SLOT_CEX0 + k] = (cap_cnt != xbar_pkg::CAP_RESERVED)
        && (k < int'(cap_cnt));
    end
    slot_en[17] = fsel1[xbar_pkg::FS1_ECI];
    slot_en[18] = fsel1[xbar_pkg::FS1_T0];
    slot_en[19] = fsel1[xbar_pkg::FS1_T1];
    if (!xbar_en) begin
      slot_en = '0;
    end
  end

  // ---------------------------------------------------------------
  // priority decode: walk pins low to high, hand each free pin to
  // the next enabled slot. a ripple chain, fine at 25 MHz.
  // ---------------------------------------------------------------
  logic [23:0] taken;
  logic [23:0] assigned;
  logic [23:0] is_uart;
  logic [4:0] pin_slot [24];
  logic [xbar_pkg::NUM_SLOTS-1:0] pending;

  function automatic logic [4:0] first_set(
    input logic [xbar_pkg::NUM_SLOTS-1:0] v
  );
    logic [4:0] r;
    r = 5'h1F;
    for (int j = xbar_pkg::NUM_SLOTS - 1; j >= 0; j--) begin
      if (v[j]) begin
        r = 5'(j);
      end
    end
    return r;
  endfunction

  always_comb begin
    is_uart = '0;
    if (xbar_en && uart_en) begin
      is_uart[xbar_pkg::UART_TX_PIN] = 1'b1;
      is_uart[xbar_pkg::UART_RX_PIN] = 1'b1;
    end
    taken = is_uart | cfg.skip;
    pending = slot_en;
    assigned = '0;
    for (int p = 0; p < 24; p++) begin
      pin_slot[p] = 5'h1F;
      if (!taken[p] && (pending != '0)) begin
        pin_slot[p] = first_set(pending);
        assigned[p] = 1'b1;
        pending[pin_slot[p]] = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin cell: driver, drive mode, pull-up
  // ---------------------------------------------------------------
  logic [23:0] next_out;
  logic [23:0] next_oe;
  logic [23:0] next_pullup;
  logic [23:0] next_read;
  logic [xbar_pkg::NUM_SLOTS-1:0] next_pin_in;
  logic next_rx;

  always_comb begin
    next_pin_in = '0;
    next_rx = 1'b1;
    for (int p = 0; p < 24; p++) begin
      logic data;
      logic drive_en;
      logic open_drain;
      logic digital;
      data = cfg.latch[p];
      drive_en = 1'b1;
      digital = cfg.input_mode[p];
      open_drain = !cfg.output_mode[p];
      if (is_uart[p]) begin
        data = (p == xbar_pkg::UART_TX_PIN) ? i_periph.uart_tx : 1'b1;
        drive_en = (p == xbar_pkg::UART_TX_PIN);
        if (p == xbar_pkg::UART_RX_PIN) begin
          next_rx = pin_sync[p] | !digital;
        end
      end else if (assigned[p]) begin
        data = i_periph.out[pin_slot[p]];
        drive_en = i_periph.oe[pin_slot[p]];
        next_pin_in[pin_slot[p]] = pin_sync[p] & digital;
        if (pin_slot[p] == 5'(xbar_pkg::SLOT_SDA) ||
            pin_slot[p] == 5'(xbar_pkg::SLOT_SCL)) begin
          open_drain = 1'b1;
        end
      end
      next_out[p] = 1'b0;
      next_oe[p] = 1'b0;
      if (xbar_en && digital && drive_en) begin
        next_out[p] = data;
        next_oe[p] = !(open_drain && data);
      end
      next_pullup[p] = open_drain && digital && !fsel1[xbar_pkg::FS1_PU_DIS]
        && !(next_oe[p] && !next_out[p]);
      next_read[p] = pin_sync[p] & digital;
    end
  end

  // all outputs registered
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pin_out <= 24'h000000;
      o_pin_oe <= 24'h000000;
      o_pin_pullup <= 24'hFFFFFF;
      o_port_read <= 24'h000000;
      o_periph_in <= '0;
      o_serial_receive_pin <= 1'b1;
    end else begin
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
      o_pin_pullup <= next_pullup;
      o_port_read <= next_read;
      o_periph_in <= next_pin_in;
      o_serial_receive_pin <= next_rx;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence xbar_off_s;
    !fsel1[xbar_pkg::FS1_XBAR_EN];
  endsequence

  sequence serial_on_s;
    xbar_en && uart_en && cfg.input_mode[xbar_pkg::UART_TX_PIN];
  endsequence

  // pins carrying an smbus slot; their drive mode is forced
  logic [23:0] smb_pin;
  logic [23:0] want_pullup;

  always_comb begin
    for (int p = 0; p < 24; p++) begin
      smb_pin[p] = assigned[p] &&
        (pin_slot[p] == 5'(xbar_pkg::SLOT_SDA) ||
         pin_slot[p] == 5'(xbar_pkg::SLOT_SCL));
    end
  end

  // open-drain digital pins want a pull-up unless the pull-up disable bit is set; driving low is masked in the check below
  assign want_pullup = (~cfg.output_mode | smb_pin) & cfg.input_mode
    & {24{!fsel1[xbar_pkg::FS1_PU_DIS]}};

  no_drive_off_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    xbar_off_s |=> o_pin_oe == 24'h000000)
    else $error("pin driven while crossbar off");
  periph_off_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    xbar_off_s |=> o_periph_in == '0 && o_serial_receive_pin)
    else $error("peripheral sees pins while crossbar off");
  analog_quiet_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (~$past(cfg.input_mode) & (o_pin_oe | o_pin_pullup | o_port_read))
      == 24'h000000)
    else $error("analog pin not quiet");
  od_high_z_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (o_pin_oe & o_pin_out & ~$past(cfg.output_mode)) == 24'h000000)
    else $error("open-drain pin drove high");
  smb_od_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (o_pin_oe & o_pin_out & $past(smb_pin)) == 24'h000000)
    else $error("smbus pin drove high");
  pull_low_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (o_pin_pullup & o_pin_oe & ~o_pin_out) == 24'h000000)
    else $error("pull-up on while driving low");
  pullup_rule_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_pin_pullup == ($past(want_pullup) & ~(o_pin_oe & ~o_pin_out)))
    else $error("pull-up wrong for drive mode");
  uart_tx_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    serial_on_s |=> o_pin_out[4] == $past(i_periph.uart_tx)
      && o_pin_oe[4] == ($past(cfg.output_mode[4]) ||
                         !$past(i_periph.uart_tx)))
    else $error("transmit not on fixed pin");
  skip_honour_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (assigned & cfg.skip) == 24'h000000)
    else $error("skipped pin assigned");
  first_pin_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    slot_en[0] && !taken[0] |-> pin_slot[0] == 5'h00)
    else $error("top slot not on lowest free pin");
  cap_count_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    xbar_en && cap_cnt != xbar_pkg::CAP_RESERVED |->
      $countones(slot_en[xbar_pkg::SLOT_CEX0 +: 6]) == int'(cap_cnt))
    else $error("capture outputs miscounted");
  cap_reserved_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    cap_cnt == xbar_pkg::CAP_RESERVED |->
      slot_en[xbar_pkg::SLOT_CEX0 +: 6] == 6'h00)
    else $error("reserved capture count routed outputs");
  read_live_a: assert property (
    @(posedge i_clk) disable iff (i_reset)
    o_port_read == ($past(pin_sync) & $past(cfg.input_mode)))
    else $error("port read not live pin");
endmodule

// ===== dv/pad_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// outside circuitry on the pads
// ---------------------------------------------------------------
module pad_model (
  input wire logic i_clk,
  input wire logic [23:0] i_pin_out,
  input wire logic [23:0] i_pin_oe,
  input wire logic [23:0] i_pin_pullup,
  input wire logic [23:0] i_ext_en,
  input wire logic [23:0] i_ext_val,
  output logic [23:0] o_pad
);
  logic [23:0] float_val = 24'h000000;
  // a floating pad toggles so a stale level never passes for a real one
  always_ff @(posedge i_clk) begin
    float_val <= ~float_val;
  end
  // device drive wins, then an outside source, then the weak pull-up
  always_comb begin
    for (int n = 0; n < 24; n++) begin
      if (i_pin_oe[n])
        o_pad[n] = i_pin_out[n];
      else if (i_ext_en[n])
        o_pad[n] = i_ext_val[n];
      else if (i_pin_pullup[n])
        o_pad[n] = 1'b1;
      else
        o_pad[n] = float_val[n];
    end
  end
endmodule

// ===== dv/test_priority_crossbar_port_io.sv
`timescale 1ns/100ps
module test_priority_crossbar_port_io;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  xbar_pkg::port_cfg_s cfg = {xbar_pkg::RST_INPUT_MODE,
                              xbar_pkg::RST_OUTPUT_MODE,
                              xbar_pkg::RST_SKIP, xbar_pkg::RST_LATCH};
  logic [7:0] fs0 = 8'h00;
  logic [7:0] fs1 = 8'h00;
  logic [1:0] ssm = 2'h0;
  xbar_pkg::periph_out_s per = '0;
  logic [23:0] ext_en = 24'h000000;
  logic [23:0] ext_val = 24'h000000;
  logic [23:0] pad, pout, poe, ppu, pread;
  logic [19:0] pin_in;
  logic rx;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  priority_crossbar_port_io i_priority_crossbar_port_io (
    .i_clk(i_clk), .i_reset(i_reset), .i_cfg(cfg),
    .i_function_select_0(fs0), .i_function_select_1(fs1),
    .i_slave_select_mode_bits(ssm), .i_periph(per), .i_pin(pad),
    .o_pin_out(pout), .o_pin_oe(poe), .o_pin_pullup(ppu),
    .o_port_read(pread), .o_periph_in(pin_in), .o_serial_receive_pin(rx));
  pad_model i_pad_model (
    .i_clk(i_clk), .i_pin_out(pout), .i_pin_oe(poe), .i_pin_pullup(ppu),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // config reaches the pads two edges later, the pad read three more
  task settle;
    repeat (5) @(posedge i_clk);
    #1;
  endtask
  // lowest n pins not skipped, in pin order
  function automatic logic [23:0] first_free(input int n,
                                             input logic [23:0] skip);
    logic [23:0] m;
    int k;
    m = 24'h000000;
    k = 0;
    for (int p = 0; p < 24; p++) begin
      if (!skip[p] && k < n) begin
        m[p] = 1'b1;
        k++;
      end
    end
    return m;
  endfunction
  // a hang ends the run with a mismatch counted
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (15) @(posedge i_clk);
    #1;
    check(poe, 24'h000000);
    check(ppu, 24'hFFFFFF);
    check(rx, 1'b1);
    @(posedge i_clk);
    i_reset <= 1'b0;
    fs0 <= 8'h07;
    fs1 <= 8'h06;
    cfg.latch <= 24'h000000;
    cfg.output_mode <= 24'hFFFFFF;
    ext_en <= 24'hFFFFFF;
    ext_val <= 24'hA5C396;
    settle();
    check(poe, 24'h000000);
    check(pread, 24'hA5C396);
    check(pin_in, 24'h000000);
    @(posedge i_clk);
    fs0 <= 8'h02;
    fs1 <= 8'h40;
    ext_en <= 24'h000000;
    per.out <= 20'h00005;
    per.oe <= 20'hFFFFF;
    settle();
    check(pout, 24'h000005);
    check(poe, 24'hFFFFFF);
    @(posedge i_clk);
    ssm <= 2'h2;
    per.out <= 20'h0000D;
    settle();
    check(pout, 24'h00000D);
    @(posedge i_clk);
    fs0 <= 8'h07;
    cfg.skip <= 24'h000001;
    per.out <= 20'h0003F;
    per.uart_tx <= 1'b1;
    ext_en <= 24'h0000A0;
    settle();
    check(poe, 24'hFFFE5F);
    check(pout & 24'h00005F, 24'h00005E);
    check(rx, 1'b0);
    check(pin_in[xbar_pkg::SLOT_SDA], 1'b1);
    check(ppu[8:7], 2'h3);
    @(posedge i_clk);
    fs0 <= 8'h00;
    ext_en <= 24'h000000;
    per.out <= 20'hFFFFF;
    cfg.skip <= 24'h000030;
    for (int n = 0; n < 8; n++) begin
      fs1 <= 8'h40 | 8'(n);
      settle();
      check(pout, first_free(n == 7 ? 0 : n, 24'h000030));
      @(posedge i_clk);
    end
    // lower ranks in their fixed order, past skipped pins 4 and 5
    fs0 <= 8'hF8;
    fs1 <= 8'h78;
    per.out <= 20'h40540;
    settle();
    check(pout, 24'h000145);
    @(posedge i_clk);
    fs0 <= 8'h00;
    // modes and skips go in with the fs1 write, crossbar already enabled
    cfg.output_mode <= 24'h000000;
    cfg.latch <= 24'hFFFF00;
    cfg.input_mode <= 24'hFFFBFF;
    cfg.skip <= 24'h000400;
    ext_en <= 24'h000400;
    ext_val <= 24'h000400;
    fs1 <= 8'h40;
    settle();
    check(poe, 24'h0000FF);
    check(pout & 24'h0000FF, 24'h000000);
    check(ppu, 24'hFFFB00);
    check(pread & 24'h000C00, 24'h000800);
    @(posedge i_clk);
    fs1 <= 8'hC0;
    settle();
    check(ppu, 24'h000000);
    print_verdict();
  end
endmodule

// ===== pkg/xbar_pkg.sv
package xbar_pkg;
  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int NUM_PINS = 24;
  localparam logic [23:0] RST_INPUT_MODE = 24'hFFFFFF;
  localparam logic [23:0] RST_OUTPUT_MODE = 24'h000000;
  localparam logic [23:0] RST_SKIP = 24'h000000;
  localparam logic [23:0] RST_LATCH = 24'hFFFFFF;
  localparam logic [7:0] RST_FSEL = 8'h00;
  // ---------------------------------------------------------------
  // function select 0 field positions
  // ---------------------------------------------------------------
  localparam int FS0_UART = 0;
  localparam int FS0_SPI = 1;
  localparam int FS0_SMB = 2;
  localparam int FS0_SYSCK = 3;
  localparam int FS0_CP0 = 4;
  localparam int FS0_CP0A = 5;
  localparam int FS0_CP1 = 6;
  localparam int FS0_CP1A = 7;
  // ---------------------------------------------------------------
  // function select 1 field positions
  // ---------------------------------------------------------------
  localparam int FS1_CAP_LO = 0;
  localparam int FS1_ECI = 3;
  localparam int FS1_T0 = 4;
  localparam int FS1_T1 = 5;
  localparam int FS1_XBAR_EN = 6;
  localparam int FS1_PU_DIS = 7;
  // ---------------------------------------------------------------
  // fixed serial port pins
  // ---------------------------------------------------------------
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;
  localparam logic [2:0] CAP_RESERVED = 3'h7;
  // ---------------------------------------------------------------
  // priority slots below the serial port, highest first:
  // spi sck, miso, mosi, nss, sda, scl, cp0, cp0a, sysclk, cp1,
  // cp1a, cex0..cex5, eci, t0, t1
  // ---------------------------------------------------------------
  localparam int NUM_SLOTS = 20;
  localparam int SLOT_NSS = 3;
  localparam int SLOT_SDA = 4;
  localparam int SLOT_SCL = 5;
  localparam int SLOT_CEX0 = 11;
  typedef logic [4:0] slot_t;
  typedef struct packed {
    logic [23:0] input_mode;
    logic [23:0] output_mode;
    logic [23:0] skip;
    logic [23:0] latch;
  } port_cfg_s;
  typedef struct packed {
    logic [NUM_SLOTS-1:0] out;
    logic [NUM_SLOTS-1:0] oe;
    logic uart_tx;
  } periph_out_s;
endpackage
